// file: erc_pkg.sv
package erc_pkg;

    // register byte offsets on the wishbone slave
    localparam logic [3:0] OFS_MODE_CTRL  = 4'h0;
    localparam logic [3:0] OFS_HARDWARE_CONTROL    = 4'h4;
    localparam logic [3:0] OFS_SUP_STAT   = 4'h8;
    localparam logic [3:0] OFS_CMD        = 4'hc;

    // mode control fields
    localparam int MC_STANDALONE = 0;
    localparam int MC_VSEL       = 1;
    localparam int MC_UV_OVR     = 2;
    localparam int MC_STP_KEEP   = 3;
    localparam int MC_REG_ON     = 4;
    // hardware control fields
    localparam int HC_LOAD_SHARE = 0;
    // status fields
    localparam int ST_ON         = 0;
    localparam int ST_HP         = 1;
    localparam int ST_LP         = 2;
    localparam int ST_OC         = 3;
    localparam int ST_UV         = 4;
    localparam int ST_SPI_FAIL   = 5;
    localparam int ST_CFG_SA     = 6;
    localparam int ST_CFG_LS     = 7;
    localparam int ST_VOLT_33    = 8;
    // command fields (write 1)
    localparam int CMD_CLR_OC    = 0;
    localparam int CMD_CLR_FAIL  = 1;
    localparam int CMD_SOFT_RST  = 2;

    localparam logic [31:0] RST_MODE_CTRL = 32'h0000_0000;

    typedef enum logic [2:0] {
        ERC_MODE_INIT,
        ERC_MODE_NORMAL,
        ERC_MODE_STOP,
        ERC_MODE_SLEEP,
        ERC_MODE_RESTART,
        ERC_MODE_FAILSAFE
    } erc_mode_t;

    typedef enum logic [1:0] {
        ERC_CFG_NONE,
        ERC_CFG_STANDALONE,
        ERC_CFG_SHARE
    } erc_cfg_t;

    // analog sense inputs, all asynchronous
    typedef struct packed {
        logic batt_uv;
        logic base_peak_rise;
        logic base_peak_fall;
        logic shunt_oc;
        logic main_ramp_ok;
    } erc_sense_t;

    // drive to the analog regulator
    typedef struct packed {
        logic reg_on;
        logic hp_stage;
        logic lp_stage;
        logic volt_33;
    } erc_drive_t;

endpackage

// file: erc_sync.sv
`timescale 1ns/100ps
// two-stage synchroniser for a bundle of asynchronous levels
module erc_sync #(
    parameter int WIDTH = 5
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// file: erc_cfg_lock.sv
`timescale 1ns/100ps
// one-time configuration latch, cleared only by power-on reset
module erc_cfg_lock (
    // clock and power-on reset
    input  wire logic              mclk,
    input  wire logic              por_n,
    // requests from the register writes
    input  wire logic              req_standalone,
    input  wire logic              req_share,
    // locked result and refusal pulses
    output erc_pkg::erc_cfg_t      cfg,
    output logic                   change_refused
);

    wire first_sa   = (cfg == erc_pkg::ERC_CFG_NONE) && req_standalone && !req_share;
    wire first_ls   = (cfg == erc_pkg::ERC_CFG_NONE) && req_share;
    // a differing request after share is locked is a refused change
    wire ls_changed = (cfg == erc_pkg::ERC_CFG_SHARE) && (req_standalone || !req_share);
    wire sa_changed = (cfg == erc_pkg::ERC_CFG_STANDALONE) && (req_share || !req_standalone);

    always_ff @(posedge mclk) begin
        if (!por_n) begin
            cfg            <= erc_pkg::ERC_CFG_NONE;
            change_refused <= 1'b0;
        end else begin
            if (first_ls) begin
                cfg <= erc_pkg::ERC_CFG_SHARE;                  // [RULE2] [RULE3]
            end else if (first_sa) begin
                cfg <= erc_pkg::ERC_CFG_STANDALONE;             // [RULE1] [RULE3]
            end
            change_refused <= ls_changed;                       // [RULE18]
        end
    end

    a_lock_holds: assert property (@(posedge mclk) disable iff (!por_n)
        $past(cfg) != erc_pkg::ERC_CFG_NONE |-> cfg == $past(cfg))   // [RULE3]
        else $error("locked configuration changed");

    a_sa_no_fail: assert property (@(posedge mclk) disable iff (!por_n)
        cfg == erc_pkg::ERC_CFG_STANDALONE && sa_changed |=> !change_refused)
        else $error("refusal flagged in stand-alone role");

endmodule

// file: erc_ctrl.sv
`timescale 1ns/100ps
// Function
// RULE1 - stand-alone bit in normal mode selects independent
// RULE2 - load-share bit selects load-sharing role
// RULE3 - first selection locks the role
// RULE4 - lock survives soft reset, power-on clears
// RULE5 - voltage select 0=5.0V 1=3.3V stand-alone
// RULE6 - battery undervoltage switches regulator off
// RULE7 - regulator returns when battery recovers
// RULE8 - override bit keeps regulator on
// RULE9 - stop mode on only if keep-on and sharing; stand-alone keeps its frozen on/off state in stop
// RULE10 - status register reports regulator condition
// RULE11 - init and fail-safe hold regulator off
// RULE12 - sharing follows main regulator by mode
// RULE13 - stand-alone state frozen outside normal mode
// RULE14 - stop mode: rising peak enables high stage
// RULE15 - stop mode: falling peak disables high stage
// RULE16 - normal mode runs high stage only
// RULE17 - software configures right after power-up
// RULE18 - change after sharing locked sets fail flag
// RULE19 - shunt threshold sets clearable overcurrent flag
// RULE20 - sharing paused in stop, resumes in normal
// RULE21 - locked bits ignore writes, read back lock
module erc_ctrl (
    // clock and resets
    input  wire logic                 mclk,
    input  wire logic                 rst_n,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [3:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    output logic                      wb_err_o,
    // chip operating mode from the state machine
    input  wire erc_pkg::erc_mode_t   chip_mode,
    // analog sense levels
    input  wire erc_pkg::erc_sense_t  sense_async,
    // regulator drive
    output erc_pkg::erc_drive_t       drive
);

    ////////////////////////////////////////////////////////////////////////
    // soft reset: control, flag and drive registers; not the configuration lock, synchroniser or bus registers

    logic soft_rst;
    wire  ctl_rst_n = rst_n && !soft_rst;                                   // [RULE4]

    ////////////////////////////////////////////////////////////////////////
    // sense synchronisation

    erc_pkg::erc_sense_t sense;

    erc_sync #(
        .WIDTH ($bits(erc_pkg::erc_sense_t))
    ) u_sync (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .async_in (sense_async),
        .sync_out (sense)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    wire req       = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    wire hit_mc    = wb_adr_i == erc_pkg::OFS_MODE_CTRL;
    wire hit_hc    = wb_adr_i == erc_pkg::OFS_HARDWARE_CONTROL;
    wire hit_st    = wb_adr_i == erc_pkg::OFS_SUP_STAT;
    wire hit_cmd   = wb_adr_i == erc_pkg::OFS_CMD;
    wire mapped    = hit_mc || hit_hc || hit_st || hit_cmd;
    // writes commit at the edge where the master still holds the request and sees ack
    wire wr        = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && mapped;
    wire wr_mc     = wr && hit_mc;
    wire wr_hc     = wr && hit_hc;
    wire wr_cmd    = wr && hit_cmd;

    logic [7:0] mode_ctrl;
    logic       ls_bit;
    logic       oc_flag;
    logic       fail_flag;
    logic       reg_on_frozen;
    logic       hp_stop;

    erc_pkg::erc_cfg_t cfg;
    logic              refused;

    wire cfg_sa = cfg == erc_pkg::ERC_CFG_STANDALONE;
    wire cfg_ls = cfg == erc_pkg::ERC_CFG_SHARE;

    wire is_init   = chip_mode == erc_pkg::ERC_MODE_INIT;
    wire is_normal = chip_mode == erc_pkg::ERC_MODE_NORMAL;
    wire is_stop   = chip_mode == erc_pkg::ERC_MODE_STOP;
    wire is_sleep  = chip_mode == erc_pkg::ERC_MODE_SLEEP;
    wire is_rst_md = chip_mode == erc_pkg::ERC_MODE_RESTART;
    wire is_fs     = chip_mode == erc_pkg::ERC_MODE_FAILSAFE;

    // stand-alone request only counts in normal mode
    wire sa_req    = wr_mc && is_normal && wb_dat_i[erc_pkg::MC_STANDALONE];    // [RULE1]
    wire ls_req    = wr_hc && wb_dat_i[erc_pkg::HC_LOAD_SHARE];                 // [RULE2]
    wire cfg_wr_mc = wr_mc && is_normal;

    // without a write the lock sees its own state, so no change is flagged
    erc_cfg_lock u_lock (
        .mclk           (mclk),
        .por_n          (rst_n),
        .req_standalone (cfg_wr_mc ? sa_req : cfg_sa),
        .req_share      (wr_hc ? ls_req : cfg_ls),
        .cfg            (cfg),
        .change_refused (refused)
    );

    ////////////////////////////////////////////////////////////////////////
    // control registers

    always_ff @(posedge mclk) begin
        if (!ctl_rst_n) begin
            mode_ctrl <= erc_pkg::RST_MODE_CTRL[7:0];
            ls_bit    <= 1'b0;
        end else begin
            if (wr_mc && is_normal) begin
                mode_ctrl <= wb_dat_i[7:0];
            end
            if (wr_hc && cfg == erc_pkg::ERC_CFG_NONE) begin
                ls_bit <= wb_dat_i[erc_pkg::HC_LOAD_SHARE];
            end
        end
    end

    wire uv_ovr   = mode_ctrl[erc_pkg::MC_UV_OVR];
    wire stp_keep = mode_ctrl[erc_pkg::MC_STP_KEEP];
    wire sw_on    = mode_ctrl[erc_pkg::MC_REG_ON];

    ////////////////////////////////////////////////////////////////////////
    // on/off decision per chip mode

    wire uv_off   = sense.batt_uv && !uv_ovr;                               // [RULE6] [RULE7] [RULE8]

    logic mode_on;
    always_comb begin
        mode_on = 1'b0;
        if (cfg_ls) begin
            case (chip_mode)
                erc_pkg::ERC_MODE_NORMAL:  mode_on = 1'b1;                  // [RULE12]
                erc_pkg::ERC_MODE_STOP:    mode_on = stp_keep;              // [RULE9] [RULE20]
                erc_pkg::ERC_MODE_RESTART: mode_on = sense.main_ramp_ok;    // [RULE12]
                default:                   mode_on = 1'b0;                  // [RULE11] [RULE12]
            endcase
        end else if (cfg_sa) begin
            case (chip_mode)
                erc_pkg::ERC_MODE_NORMAL:  mode_on = sw_on;
                erc_pkg::ERC_MODE_STOP,
                erc_pkg::ERC_MODE_SLEEP,
                erc_pkg::ERC_MODE_RESTART: mode_on = reg_on_frozen;         // [RULE13]
                default:                   mode_on = 1'b0;                  // [RULE11]
            endcase
        end
    end

    wire next_on = mode_on && !uv_off;

    ////////////////////////////////////////////////////////////////////////
    // stage selection and flags

    wire next_hp_stop = hp_stop ? !sense.base_peak_fall : sense.base_peak_rise;
    wire oc_set       = cfg_sa && sense.shunt_oc;
    wire oc_clr       = wr_cmd && wb_dat_i[erc_pkg::CMD_CLR_OC] && !sense.shunt_oc;
    wire fail_clr     = wr_cmd && wb_dat_i[erc_pkg::CMD_CLR_FAIL];

    always_ff @(posedge mclk) begin
        if (!ctl_rst_n) begin
            reg_on_frozen <= 1'b0;
            hp_stop       <= 1'b0;
            oc_flag       <= 1'b0;
            fail_flag     <= 1'b0;
        end else begin
            if (is_normal) begin
                reg_on_frozen <= sw_on;                                     // [RULE13]
            end
            hp_stop   <= is_stop && next_hp_stop;                           // [RULE14] [RULE15]
            oc_flag   <= oc_set || (oc_flag && !oc_clr);                    // [RULE19]
            fail_flag <= refused || (fail_flag && !fail_clr);               // [RULE18]
        end
    end

    always_ff @(posedge mclk) begin
        if (!ctl_rst_n) begin
            drive <= '0;
        end else begin
            drive.reg_on   <= next_on;
            drive.hp_stage <= next_on && (is_normal || (is_stop ? next_hp_stop : 1'b1)); // [RULE16]
            drive.lp_stage <= next_on && !is_normal;                        // [RULE16]
            drive.volt_33  <= cfg_sa && mode_ctrl[erc_pkg::MC_VSEL];        // [RULE5]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status and read mux

    logic [31:0] status;
    always_comb begin
        status = 32'h0000_0000;
        status[erc_pkg::ST_ON]       = drive.reg_on;                        // [RULE10]
        status[erc_pkg::ST_HP]       = drive.hp_stage;
        status[erc_pkg::ST_LP]       = drive.lp_stage;
        status[erc_pkg::ST_OC]       = oc_flag;
        status[erc_pkg::ST_UV]       = cfg_sa && sense.batt_uv;
        status[erc_pkg::ST_SPI_FAIL] = fail_flag;
        status[erc_pkg::ST_CFG_SA]   = cfg_sa;
        status[erc_pkg::ST_CFG_LS]   = cfg_ls;
        status[erc_pkg::ST_VOLT_33]  = drive.volt_33;
    end

    // configuration bits read back the lock, not the last write
    wire [7:0] mc_rd = {mode_ctrl[7:1], cfg_sa};                            // [RULE21]
    wire [31:0] rd_data = hit_mc ? {24'h00_0000, mc_rd} :
                          hit_hc ? {31'h0000_0000, cfg_ls} :                // [RULE21]
                          hit_st ? status : 32'h0000_0000;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            soft_rst <= 1'b0;
        end else begin
            wb_ack_o <= req && mapped;
            wb_err_o <= req && !mapped;
            wb_dat_o <= (req && !wb_we_i) ? rd_data : 32'h0000_0000;
            soft_rst <= wr_cmd && wb_dat_i[erc_pkg::CMD_SOFT_RST];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    a_init_fs_off: assert property (@(posedge mclk) disable iff (!ctl_rst_n)
        (is_init || is_fs) |=> !drive.reg_on)                               // [RULE11]
        else $error("regulator on in init or fail-safe");

    a_uv_shutdown: assert property (@(posedge mclk) disable iff (!ctl_rst_n)
        (sense.batt_uv && !uv_ovr) |=> !drive.reg_on)                       // [RULE6]
        else $error("regulator on during undervoltage");

    a_uv_override: assert property (@(posedge mclk) disable iff (!ctl_rst_n)
        (mode_on && uv_ovr) |=> drive.reg_on)                               // [RULE8]
        else $error("override did not keep regulator on");

    a_stop_keep_on: assert property (@(posedge mclk) disable iff (!ctl_rst_n)
        (is_stop && !(stp_keep && cfg_ls) && !cfg_sa) |=> !drive.reg_on)    // [RULE9]
        else $error("regulator on in stop without keep-on");

    a_normal_hp_only: assert property (@(posedge mclk) disable iff (!ctl_rst_n)
        (is_normal && next_on) |=> (drive.hp_stage && !drive.lp_stage))     // [RULE16]
        else $error("normal mode stage selection wrong");

    a_oc_standalone: assert property (@(posedge mclk) disable iff (!ctl_rst_n)
        (!cfg_sa && !oc_flag) |=> !oc_flag)                                 // [RULE19]
        else $error("overcurrent set outside stand-alone");

    a_vsel_ignored: assert property (@(posedge mclk) disable iff (!ctl_rst_n)
        cfg_ls |=> !drive.volt_33)                                          // [RULE5]
        else $error("voltage select honoured in sharing role");

    a_share_fail: assert property (@(posedge mclk) disable iff (!rst_n)
        (cfg_ls && wr_hc && !wb_dat_i[0]) |-> ##2 fail_flag)                // [RULE18]
        else $error("refused change did not set fail flag");

endmodule

// file: tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic                mclk;
    logic                rst_n;
    logic                wb_cyc_i;
    logic                wb_stb_i;
    logic                wb_we_i;
    logic [3:0]          wb_adr_i;
    logic [3:0]          wb_sel_i;
    logic [31:0]         wb_dat_i;
    logic [31:0]         wb_dat_o;
    logic                wb_ack_o;
    logic                wb_err_o;
    erc_pkg::erc_mode_t  chip_mode;
    erc_pkg::erc_sense_t sense_async;
    erc_pkg::erc_drive_t drive;
    int                  miscompares;
    int                  samples_checked;
    logic [31:0]         rd;
    logic                got_err;

    erc_ctrl dut (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .chip_mode(chip_mode), .sense_async(sense_async), .drive(drive));

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // one classic cycle, held until ack or err is seen
    task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge mclk);
            n++;
        end while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1) && n < 50);
        if (n >= 50) miscompares++;
        rd = wb_dat_o;
        got_err = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    // let sense levels pass the synchroniser and the drive register
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic set_mode(input erc_pkg::erc_mode_t m);
        @(posedge mclk);
        chip_mode <= m;
        settle(3);
    endtask

    task automatic por();
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        settle(1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_bus();
        wb(1'b0, erc_pkg::OFS_MODE_CTRL, 32'h0);
        chk(rd, erc_pkg::RST_MODE_CTRL);
        wb(1'b0, erc_pkg::OFS_SUP_STAT, 32'h0);
        chk(rd & 32'h1ff, 32'h0);
        chk({28'h0, drive}, 32'h0);
        wb(1'b1, 4'h2, 32'h1);
        chk({31'h0, got_err}, 32'h1);
        $display("test reset_bus done");
    endtask

    task automatic t_standalone();
        wb(1'b1, erc_pkg::OFS_MODE_CTRL, 32'h13);
        settle(2);
        chk({28'h0, drive}, 32'hd);
        wb(1'b0, erc_pkg::OFS_SUP_STAT, 32'h0);
        chk(rd & 32'h1e3, 32'h143);
        wb(1'b1, erc_pkg::OFS_HARDWARE_CONTROL, 32'h1);
        wb(1'b0, erc_pkg::OFS_HARDWARE_CONTROL, 32'h0);
        chk(rd & 32'h1, 32'h0);
        wb(1'b0, erc_pkg::OFS_SUP_STAT, 32'h0);
        chk(rd & 32'he0, 32'h40);
        set_mode(erc_pkg::ERC_MODE_STOP);
        chk({31'h0, drive.reg_on}, 32'h1);
        set_mode(erc_pkg::ERC_MODE_SLEEP);
        chk({31'h0, drive.reg_on}, 32'h1);
        set_mode(erc_pkg::ERC_MODE_FAILSAFE);
        chk({31'h0, drive.reg_on}, 32'h0);
        set_mode(erc_pkg::ERC_MODE_NORMAL);
        $display("test standalone done");
    endtask

    task automatic t_supply();
        sense_async.batt_uv <= 1'b1;
        settle(5);
        chk({31'h0, drive.reg_on}, 32'h0);
        sense_async.batt_uv <= 1'b0;
        settle(5);
        chk({31'h0, drive.reg_on}, 32'h1);
        wb(1'b1, erc_pkg::OFS_MODE_CTRL, 32'h17);
        sense_async.batt_uv <= 1'b1;
        settle(5);
        chk({31'h0, drive.reg_on}, 32'h1);
        sense_async.batt_uv <= 1'b0;
        sense_async.shunt_oc <= 1'b1;
        settle(5);
        wb(1'b1, erc_pkg::OFS_CMD, 32'h1);
        wb(1'b0, erc_pkg::OFS_SUP_STAT, 32'h0);
        chk(rd & 32'h8, 32'h8);
        sense_async.shunt_oc <= 1'b0;
        settle(5);
        wb(1'b1, erc_pkg::OFS_CMD, 32'h1);
        wb(1'b0, erc_pkg::OFS_SUP_STAT, 32'h0);
        chk(rd & 32'h8, 32'h0);
        wb(1'b1, erc_pkg::OFS_CMD, 32'h4);
        settle(2);
        wb(1'b0, erc_pkg::OFS_MODE_CTRL, 32'h0);
        chk(rd & 32'h1, 32'h1);
        wb(1'b0, erc_pkg::OFS_SUP_STAT, 32'h0);
        chk(rd & 32'hc0, 32'h40);
        por();
        wb(1'b0, erc_pkg::OFS_SUP_STAT, 32'h0);
        chk(rd & 32'hc0, 32'h0);
        $display("test supply done");
    endtask

    task automatic t_share();
        set_mode(erc_pkg::ERC_MODE_NORMAL);
        wb(1'b1, erc_pkg::OFS_HARDWARE_CONTROL, 32'h1);
        wb(1'b1, erc_pkg::OFS_MODE_CTRL, 32'h2);
        settle(2);
        chk({28'h0, drive}, 32'hc);
        wb(1'b0, erc_pkg::OFS_SUP_STAT, 32'h0);
        chk(rd & 32'he0, 32'h80);
        wb(1'b1, erc_pkg::OFS_HARDWARE_CONTROL, 32'h0);
        settle(2);
        wb(1'b0, erc_pkg::OFS_SUP_STAT, 32'h0);
        chk(rd & 32'h20, 32'h20);
        wb(1'b0, erc_pkg::OFS_HARDWARE_CONTROL, 32'h0);
        chk(rd & 32'h1, 32'h1);
        wb(1'b1, erc_pkg::OFS_CMD, 32'h2);
        wb(1'b0, erc_pkg::OFS_SUP_STAT, 32'h0);
        chk(rd & 32'h20, 32'h0);
        set_mode(erc_pkg::ERC_MODE_SLEEP);
        chk({31'h0, drive.reg_on}, 32'h0);
        sense_async.main_ramp_ok <= 1'b1;
        set_mode(erc_pkg::ERC_MODE_RESTART);
        settle(3);
        chk({31'h0, drive.reg_on}, 32'h1);
        set_mode(erc_pkg::ERC_MODE_STOP);
        chk({31'h0, drive.reg_on}, 32'h0);
        set_mode(erc_pkg::ERC_MODE_NORMAL);
        chk({31'h0, drive.reg_on}, 32'h1);
        $display("test share done");
    endtask

    task automatic t_stop_stage();
        wb(1'b1, erc_pkg::OFS_MODE_CTRL, 32'h8);
        set_mode(erc_pkg::ERC_MODE_STOP);
        chk({28'h0, drive}, 32'ha);
        sense_async.base_peak_rise <= 1'b1;
        settle(5);
        chk({28'h0, drive}, 32'he);
        sense_async.base_peak_rise <= 1'b0;
        sense_async.base_peak_fall <= 1'b1;
        settle(5);
        chk({28'h0, drive}, 32'ha);
        sense_async.batt_uv <= 1'b1;
        settle(5);
        chk({31'h0, drive.reg_on}, 32'h0);
        set_mode(erc_pkg::ERC_MODE_INIT);
        chk({31'h0, drive.reg_on}, 32'h0);
        $display("test stop_stage done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #40000;
        miscompares++;
        finish_test();
    end

    initial begin
        miscompares = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 4'h0;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        chip_mode = erc_pkg::ERC_MODE_NORMAL;
        sense_async = '0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset_bus();
        t_standalone();
        t_supply();
        t_share();
        t_stop_stage();
        finish_test();
    end
endmodule
